// File: rtl/external_data_stretch_timing.sv
// read and write strobe sequencer for external data moves with a stretch setting
// assumes an apb master on mclk and a move request from the core on the same clock
`timescale 1ns/1ps
// How it works
// - stretch code comes from clock control register
// - move lasts 2,3,4,5,9,10,11,12 machine cycles
// - strobe is N base widths, code 0 half
// - base period follows the clock selection mode
// - divide field resets to binary 10
module external_data_stretch_timing #(
	parameter int unsigned PMM_MCS_TICKS = stretch_timing_pkg::MCS_PMM_TICKS,
	parameter int unsigned PMM_WB_TICKS = stretch_timing_pkg::WB_PMM_TICKS,
	parameter int CW = 20
) (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic moveReq, // external_data_move request, held until ack
	input wire logic moveWrite, // 1 for a write move
	output logic moveAck, // request taken this cycle
	output logic moveDone, // one-cycle pulse when the move ends
	output logic moveBusy, // move in progress
	output logic rdStrobe_b, // read strobe, active low
	output logic wrStrobe_b // write strobe, active low
);
	logic [2:0] stretchSelect, next_stretchSelect;
	logic clockDoubleSelect, next_clockDoubleSelect;
	logic [1:0] clockDivideSelect, next_clockDivideSelect;
	stretch_timing_pkg::move_state_t state, next_state;
	logic [CW-1:0] phaseCnt, next_phaseCnt;
	logic [CW-1:0] curMachine, next_curMachine;
	logic [CW-1:0] curWidth, next_curWidth;
	logic [CW-1:0] curTotal, next_curTotal;
	logic [2:0] curCode, next_curCode;
	logic curWrite, next_curWrite;
	logic next_rdStrobe_b, next_wrStrobe_b, next_moveDone;
	logic [CW-1:0] mcsTicks, wbTicks, machineTicks, widthTicks, totalTicks;
	logic [3:0] machineCycles;
	logic timerLoad, timerExpired;
	logic apbWrite, addrHit;
	////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped addresses answer pslverr
	assign apbWrite = psel && penable && pwrite;
	assign addrHit = (paddr == stretch_timing_pkg::ADDR_CLOCK_CONTROL) ||
		(paddr == stretch_timing_pkg::ADDR_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrHit;
	// read mux; the status word shows the live sequencer state
	always_comb
	begin
		prdata = 32'h0;
		if (paddr == stretch_timing_pkg::ADDR_CLOCK_CONTROL)
		begin
			prdata[stretch_timing_pkg::STRETCH_LSB +: 3] = stretchSelect;
			prdata[stretch_timing_pkg::DOUBLE_BIT] = clockDoubleSelect;
			prdata[stretch_timing_pkg::DIVIDE_LSB +: 2] = clockDivideSelect;
		end
		else if (paddr == stretch_timing_pkg::ADDR_STATUS)
		begin
			prdata[0] = moveBusy;
			prdata[1] = !rdStrobe_b;
			prdata[2] = !wrStrobe_b;
			prdata[6:4] = curCode;
		end
	end
	// clock_control_reg next values; mid-move writes only affect the next move
	always_comb
	begin
		next_stretchSelect = stretchSelect;
		next_clockDoubleSelect = clockDoubleSelect;
		next_clockDivideSelect = clockDivideSelect;
		if (apbWrite && paddr == stretch_timing_pkg::ADDR_CLOCK_CONTROL)
		begin
			next_stretchSelect = pwdata[stretch_timing_pkg::STRETCH_LSB +: 3];
			next_clockDoubleSelect = pwdata[stretch_timing_pkg::DOUBLE_BIT];
			next_clockDivideSelect = pwdata[stretch_timing_pkg::DIVIDE_LSB +: 2];
		end
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stretchSelect <= stretch_timing_pkg::STRETCH_RESET;
			clockDoubleSelect <= stretch_timing_pkg::DOUBLE_RESET;
			clockDivideSelect <= stretch_timing_pkg::DIVIDE_RESET;
		end
		else
		begin
			stretchSelect <= next_stretchSelect;
			clockDoubleSelect <= next_clockDoubleSelect;
			clockDivideSelect <= next_clockDivideSelect;
		end
	end
	////////////////////////////////////////////////////////////////
	// timing decode; the double bit only matters when the divide field is 0x
	always_comb
	begin
		case (clockDivideSelect)
			stretch_timing_pkg::DIV_QUARTER:
			begin
				mcsTicks = CW'(stretch_timing_pkg::MCS_DIV4_TICKS);
				wbTicks = CW'(stretch_timing_pkg::WB_DIV4_TICKS);
			end
			stretch_timing_pkg::DIV_PMM:
			begin
				mcsTicks = CW'(PMM_MCS_TICKS);
				wbTicks = CW'(PMM_WB_TICKS);
			end
			default:
			begin
				mcsTicks = clockDoubleSelect ? CW'(stretch_timing_pkg::MCS_DBL_TICKS) :
					CW'(stretch_timing_pkg::MCS_NORM_TICKS);
				wbTicks = clockDoubleSelect ? CW'(stretch_timing_pkg::WB_DBL_TICKS) :
					CW'(stretch_timing_pkg::WB_NORM_TICKS);
			end
		endcase
		// machine cycles per move: small codes add two, large ones add five
		machineCycles = stretchSelect[2] ? 4'(stretchSelect) + 4'h5 :
			4'(stretchSelect) + 4'h2;
		machineTicks = CW'(mcsTicks * stretch_timing_pkg::MCS_PER_MACHINE);
		totalTicks = CW'(machineTicks * machineCycles);
		// code zero is half the code-one width
		widthTicks = (stretchSelect == 3'h0) ? (wbTicks >> 1) :
			CW'(wbTicks * stretchSelect);
	end
	////////////////////////////////////////////////////////////////
	// move sequencer: one machine cycle of setup, the strobe, then the tail
	assign moveBusy = (state != stretch_timing_pkg::ST_IDLE);
	assign moveAck = moveReq && !moveBusy;
	assign timerLoad = (state == stretch_timing_pkg::ST_SETUP) && (phaseCnt == '0);
	always_comb
	begin
		next_state = state;
		next_phaseCnt = phaseCnt;
		next_curMachine = curMachine;
		next_curWidth = curWidth;
		next_curTotal = curTotal;
		next_curCode = curCode;
		next_curWrite = curWrite;
		next_rdStrobe_b = rdStrobe_b;
		next_wrStrobe_b = wrStrobe_b;
		next_moveDone = 1'b0;
		case (state)
			stretch_timing_pkg::ST_IDLE:
				if (moveAck)
				begin
					// settings are frozen for the whole move
					next_curMachine = machineTicks;
					next_curWidth = widthTicks;
					next_curTotal = totalTicks;
					next_curCode = stretchSelect;
					next_curWrite = moveWrite;
					next_phaseCnt = machineTicks - CW'(1);
					next_state = stretch_timing_pkg::ST_SETUP;
				end
			stretch_timing_pkg::ST_SETUP:
				if (phaseCnt == '0)
				begin
					next_rdStrobe_b = curWrite;
					next_wrStrobe_b = !curWrite;
					next_state = stretch_timing_pkg::ST_STROBE;
				end
				else
					next_phaseCnt = phaseCnt - CW'(1);
			stretch_timing_pkg::ST_STROBE:
				if (timerExpired)
				begin
					next_rdStrobe_b = 1'b1;
					next_wrStrobe_b = 1'b1;
					next_phaseCnt = curTotal - curMachine - curWidth - CW'(1);
					next_state = stretch_timing_pkg::ST_TAIL;
				end
			stretch_timing_pkg::ST_TAIL:
				if (phaseCnt == '0)
				begin
					next_moveDone = 1'b1;
					next_state = stretch_timing_pkg::ST_IDLE;
				end
				else
					next_phaseCnt = phaseCnt - CW'(1);
			default:
				next_state = stretch_timing_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= stretch_timing_pkg::ST_IDLE;
			phaseCnt <= '0;
			curMachine <= '0;
			curWidth <= '0;
			curTotal <= '0;
			curCode <= 3'h0;
			curWrite <= 1'b0;
			rdStrobe_b <= 1'b1;
			wrStrobe_b <= 1'b1;
			moveDone <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phaseCnt <= next_phaseCnt;
			curMachine <= next_curMachine;
			curWidth <= next_curWidth;
			curTotal <= next_curTotal;
			curCode <= next_curCode;
			curWrite <= next_curWrite;
			rdStrobe_b <= next_rdStrobe_b;
			wrStrobe_b <= next_wrStrobe_b;
			moveDone <= next_moveDone;
		end
	end
	// loaded with width minus one so the strobe is low exactly curWidth ticks
	strobe_width_counter #(.WIDTH(CW)) i_strobe_width_counter (
		.mclk(mclk),
		.rst_b(rst_b),
		.load(timerLoad),
		.loadValue(curWidth - CW'(1)),
		.expired(timerExpired)
	);
	////////////////////////////////////////////////////////////////
	// checking helpers: cycles busy, cycles of strobe low, first cycle after reset
	logic [CW-1:0] busyCnt, lowCnt;
	logic firstCycle;
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busyCnt <= '0;
			lowCnt <= '0;
			firstCycle <= 1'b1;
		end
		else
		begin
			busyCnt <= moveBusy ? busyCnt + CW'(1) : '0;
			lowCnt <= (!rdStrobe_b || !wrStrobe_b) ? lowCnt + CW'(1) : '0;
			firstCycle <= 1'b0;
		end
	end
	property p_code_latched;
		@(posedge mclk) disable iff (!rst_b)
		moveAck |=> (curCode == $past(stretchSelect));
	endproperty
	a_code_latched: assert property (p_code_latched) else $error("move code not latched");
	property p_move_length;
		@(posedge mclk) disable iff (!rst_b)
		moveDone |-> (busyCnt == curTotal) && (curTotal == curMachine * (curCode[2] ?
			CW'(curCode) + CW'(5) : CW'(curCode) + CW'(2)));
	endproperty
	a_move_length: assert property (p_move_length) else $error("move length wrong");
	property p_strobe_width;
		@(posedge mclk) disable iff (!rst_b)
		$rose(rdStrobe_b && wrStrobe_b) |-> lowCnt == curWidth;
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
	property p_strobe_start;
		@(posedge mclk) disable iff (!rst_b)
		$fell(rdStrobe_b && wrStrobe_b) |-> busyCnt == curMachine;
	endproperty
	a_strobe_start: assert property (p_strobe_start) else $error("strobe start wrong");
	// a move taken in power management mode freezes the slow machine cycle and strobe width
	property p_pmm_base;
		@(posedge mclk) disable iff (!rst_b)
		(moveAck && clockDivideSelect == stretch_timing_pkg::DIV_PMM) |=>
			curMachine == CW'(PMM_MCS_TICKS * stretch_timing_pkg::MCS_PER_MACHINE) &&
			curWidth == ((curCode == 3'h0) ? CW'(PMM_WB_TICKS / 2) : CW'(PMM_WB_TICKS * curCode));
	endproperty
	a_pmm_base: assert property (p_pmm_base) else $error("pmm base wrong");
	property p_reset_divide;
		@(posedge mclk) disable iff (!rst_b)
		firstCycle |-> clockDivideSelect == stretch_timing_pkg::DIVIDE_RESET;
	endproperty
	a_reset_divide: assert property (p_reset_divide) else $error("divide reset wrong");
	property p_strobe_release;
		@(posedge mclk) disable iff (!rst_b)
		(state == stretch_timing_pkg::ST_STROBE && timerExpired) |=> rdStrobe_b && wrStrobe_b;
	endproperty
	a_strobe_release: assert property (p_strobe_release) else $error("strobe not released");
	// only the strobe of the move's direction may be low, so never both at once
	property p_one_strobe;
		@(posedge mclk) disable iff (!rst_b)
		(rdStrobe_b || !curWrite) && (wrStrobe_b || curWrite);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("strobe direction wrong");
	c_read: cover property (@(posedge mclk) disable iff (!rst_b) $rose(rdStrobe_b));
	c_write: cover property (@(posedge mclk) disable iff (!rst_b) $rose(wrStrobe_b));
	c_code0: cover property (@(posedge mclk) disable iff (!rst_b) moveDone && curCode == 3'h0);
	c_code7: cover property (@(posedge mclk) disable iff (!rst_b) moveDone && curCode == 3'h7);
endmodule // external_data_stretch_timing

// File: rtl/stretch_timing_pkg.sv
// constants for the external data move stretch timing block
// assumes mclk runs at twice the oscillator rate, so one mclk is half an oscillator period
package stretch_timing_pkg;
	// clock rates and the half-oscillator tick
	localparam int MCLK_PERIOD_NS = 10;
	localparam int OSC_PERIOD_NS = 20; // oscillator_period
	localparam int TICKS_PER_OSC = OSC_PERIOD_NS / MCLK_PERIOD_NS;
	// machine cycle state base periods in oscillator periods (x2 for 0.5)
	localparam int MCS_HALF_OSC_X2 = 1; // 0.5 oscillator periods, mode 100
	localparam int MCS_NORM_OSC = 1; // mode 000
	localparam int MCS_DIV4_OSC = 4; // mode x10
	localparam int MCS_PMM_OSC = 1024; // mode x11
	// width base for stretch codes 1..7, in oscillator periods
	localparam int WB_DBL_OSC = 1;
	localparam int WB_NORM_OSC = 2;
	localparam int WB_DIV4_OSC = 4;
	localparam int WB_PMM_OSC = 4096;
	// same figures in mclk ticks
	localparam int MCS_DBL_TICKS = MCS_HALF_OSC_X2 * TICKS_PER_OSC / 2;
	localparam int MCS_NORM_TICKS = MCS_NORM_OSC * TICKS_PER_OSC;
	localparam int MCS_DIV4_TICKS = MCS_DIV4_OSC * TICKS_PER_OSC;
	localparam int MCS_PMM_TICKS = MCS_PMM_OSC * TICKS_PER_OSC;
	localparam int WB_DBL_TICKS = WB_DBL_OSC * TICKS_PER_OSC;
	localparam int WB_NORM_TICKS = WB_NORM_OSC * TICKS_PER_OSC;
	localparam int WB_DIV4_TICKS = WB_DIV4_OSC * TICKS_PER_OSC;
	localparam int WB_PMM_TICKS = WB_PMM_OSC * TICKS_PER_OSC;
	localparam int MCS_PER_MACHINE = 4;
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// clock_control_reg fields
	localparam int STRETCH_LSB = 0;
	localparam int DOUBLE_BIT = 3;
	localparam int DIVIDE_LSB = 4;
	// reset values
	localparam logic [2:0] STRETCH_RESET = 3'h1;
	localparam logic DOUBLE_RESET = 1'b0;
	localparam logic [1:0] DIVIDE_RESET = 2'h2;
	// mode encodings of clock_divide_select
	localparam logic [1:0] DIV_NORMAL = 2'h0;
	localparam logic [1:0] DIV_QUARTER = 2'h2;
	localparam logic [1:0] DIV_PMM = 2'h3;
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_TAIL} move_state_t;
endpackage

// File: rtl/strobe_width_counter.sv
// down counter that times the active strobe in mclk ticks
// assumes load is a one-cycle pulse from the move sequencer on the same clock
`timescale 1ns/1ps
module strobe_width_counter #(
	parameter int WIDTH = 20
) (
	input wire logic mclk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic load, // start a new strobe
	input wire logic [WIDTH-1:0] loadValue, // strobe length minus one
	output logic expired // count reached zero
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	////////////////////////////////////////////////////////////////
	// reload on start, otherwise count down and park at zero
	always_comb
	begin
		next_count = count;
		if (load)
			next_count = loadValue;
		else if (count != '0)
			next_count = count - WIDTH'(1);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			count <= '0;
		else
			count <= next_count;
	end

	assign expired = (count == '0);
endmodule // strobe_width_counter

// File: tb/ext_memory_model.sv
// far-side model: an external memory that times the read and write strobes it sees
// assumes strobes are active low and change only just after a rising edge of mclk
`timescale 1ns/1ps
module ext_memory_model (
	input wire logic mclk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic rdStrobe_b, // read strobe from the block
	input wire logic wrStrobe_b, // write strobe from the block
	output logic [31:0] lastWidth, // low time of the last strobe, in mclk cycles
	output logic lastWrite, // last strobe was a write
	output logic [31:0] overlaps // cycles with both strobes low
);
	logic [31:0] run;
	////////////////////////////////////////////////////////////////////////////////
	// width is latched at the first edge that sees the strobe high again
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run <= 32'h0;
			lastWidth <= 32'h0;
			lastWrite <= 1'b0;
			overlaps <= 32'h0;
		end
		else
		begin
			if (!rdStrobe_b || !wrStrobe_b)
			begin
				run <= run + 32'h1;
				lastWrite <= !wrStrobe_b;
			end
			else if (run != 32'h0)
			begin
				lastWidth <= run;
				run <= 32'h0;
			end
			// a memory cannot be read and written at once
			if (!rdStrobe_b && !wrStrobe_b)
				overlaps <= overlaps + 32'h1;
		end
	end
endmodule // ext_memory_model

// File: tb/external_data_stretch_timing_bench.sv
// self-checking bench for the stretch timing block: apb set-up, then timed moves
// assumes zero-wait apb and the small power-management counts set below
`timescale 1ns/1ps
module external_data_stretch_timing_bench;
	localparam int PMM_MCS = 8;
	localparam int PMM_WB = 16;
	localparam int CYC [8] = '{2, 3, 4, 5, 9, 10, 11, 12};
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, moveReq = 1'b0, moveWrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, lastWidth, overlaps, rd;
	logic pready, pslverr, moveAck, moveDone, moveBusy, rdStrobe_b, wrStrobe_b, lastWrite, er;
	int numErrors = 0, nCompared = 0, cycles = 0;
	external_data_stretch_timing #(.PMM_MCS_TICKS(PMM_MCS), .PMM_WB_TICKS(PMM_WB), .CW(20))
		i_external_data_stretch_timing (.mclk(mclk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .moveReq(moveReq), .moveWrite(moveWrite),
		.moveAck(moveAck), .moveDone(moveDone), .moveBusy(moveBusy),
		.rdStrobe_b(rdStrobe_b), .wrStrobe_b(wrStrobe_b));
	ext_memory_model i_ext_memory_model (.mclk(mclk), .rst_b(rst_b), .rdStrobe_b(rdStrobe_b),
		.wrStrobe_b(wrStrobe_b), .lastWidth(lastWidth), .lastWrite(lastWrite),
		.overlaps(overlaps));
	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; the longest move here is a few hundred cycles
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			numErrors++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			numErrors++;
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d compared %0d", numErrors, nCompared);
		if (numErrors == 0 && nCompared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one apb transfer; read data and error are taken at the ready edge only
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no cap here: only the bench timeout ends a hung access
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// expected timing in mclk ticks, from the mode table
	function automatic int mcs(input logic d, input logic [1:0] v);
		return v[1] ? (v[0] ? PMM_MCS : 8) : (d ? 1 : 2);
	endfunction
	function automatic int wb(input logic d, input logic [1:0] v);
		return v[1] ? (v[0] ? PMM_WB : 8) : (d ? 2 : 4);
	endfunction
	// one move; hold keeps the request up so the next one is taken in the done cycle
	task automatic do_move(input logic [2:0] c, input logic d, input logic [1:0] v,
		input logic w, input logic hold);
		int n, busyN, lows, firstLow, doneAt, bad, m, t, wd;
		m = 4 * mcs(d, v);
		t = m * CYC[c];
		wd = (c == 3'h0) ? wb(d, v) / 2 : c * wb(d, v);
		busyN = 0;
		lows = 0;
		firstLow = 0;
		doneAt = 0;
		bad = 0;
		if (moveReq !== 1'b1)
		begin
			@(posedge mclk);
			moveReq <= 1'b1;
			moveWrite <= w;
			@(negedge mclk);
		end
		while (moveAck !== 1'b1)
			@(negedge mclk);
		@(posedge mclk);
		if (!hold)
			moveReq <= 1'b0;
		for (n = 1; n < 2000 && doneAt == 0; n++)
		begin
			@(negedge mclk);
			if (moveBusy === 1'b1)
				busyN++;
			if ((w ? wrStrobe_b : rdStrobe_b) === 1'b0)
			begin
				lows++;
				if (firstLow == 0)
					firstLow = n;
			end
			if ((w ? rdStrobe_b : wrStrobe_b) !== 1'b1 || (moveBusy && moveAck))
				bad++;
			if (moveDone === 1'b1)
				doneAt = n;
		end
		check(busyN, t);
		check(doneAt, t + 1);
		check(firstLow, m + 1);
		check(lows, wd);
		check(lastWidth, wd);
		check(lastWrite, w);
		check(overlaps, 32'h0);
		check(bad, 0);
		if (hold)
			check(moveAck, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reset defaults, and the double bit ignored under the quarter divide
	task automatic t_reset();
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h21);
		do_move(3'h1, 1'b0, 2'h2, 1'b0, 1'b0);
		apb(1'b1, 8'h00, 32'h29);
		do_move(3'h1, 1'b1, 2'h2, 1'b1, 1'b0);
	endtask
	// every stretch code in double speed, reads and writes alternating
	task automatic t_codes();
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, 8'h00, 32'h8 | c);
			do_move(c[2:0], 1'b1, 2'h0, c[0], 1'b0);
		end
	endtask
	// normal, divide 01, quarter and power management modes at both ends of the stretch range, control read back each time
	task automatic t_modes();
		logic [2:0] sel [4] = '{3'h0, 3'h2, 3'h7, 3'h1};
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, 8'h00, {sel[k / 2][1:0], sel[k / 2][2], 3'h0} | ((k % 2) ? 32'h7 : 32'h0));
			apb(1'b0, 8'h00, 32'h0);
			check(rd, {sel[k / 2][1:0], sel[k / 2][2], 3'h0} | ((k % 2) ? 32'h7 : 32'h0));
			do_move((k % 2) ? 3'h7 : 3'h0, sel[k / 2][2], sel[k / 2][1:0], 1'b0, 1'b0);
		end
		apb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h70);
	endtask
	// unmapped access refused; control write in mid-move only counts for the next move
	task automatic t_refuse_b2b();
		apb(1'b1, 8'h08, 32'hffffffff);
		check(er, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h17);
		apb(1'b1, 8'h00, 32'h08);
		fork
			do_move(3'h0, 1'b1, 2'h0, 1'b1, 1'b1);
			begin
				repeat (2) @(posedge mclk);
				apb(1'b1, 8'h00, 32'h0a);
			end
		join
		do_move(3'h2, 1'b1, 2'h0, 1'b1, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_codes();
		t_modes();
		t_refuse_b2b();
		wrap_up();
	end
endmodule // external_data_stretch_timing_bench
